/* hdl/crf_params.svh */
`ifndef CRF_PARAMS_SVH
`define CRF_PARAMS_SVH

// ==========================================================
// register byte offsets
`define CRF_REG_CTRL     5'h00
`define CRF_REG_STATUS   5'h04
`define CRF_REG_INT_EN   5'h08
`define CRF_REG_INT_CLR  5'h0c
`define CRF_REG_TS_SEC   5'h10
`define CRF_REG_TS_INC   5'h14
`define CRF_REG_LOSS     5'h18

// ==========================================================
// field positions
`define CRF_CTRL_EN_BIT     0
`define CRF_EV_RECORD_BIT   0
`define CRF_EV_DROP_BIT     1
`define CRF_EV_TRUNC_BIT    2
`define CRF_FLAG_VARLEN_BIT 2
`define CRF_FLAG_TRUNC_BIT  3
`define CRF_FLAG_RXERR_BIT  4
`define CRF_FLAG_FAULT_BIT  5

// ==========================================================
// reset values and counts
`define CRF_TS_INC_RESET  32'h000000ac
`define CRF_LOSS_MAX      16'hffff
`define CRF_HDR_BYTES     16'h0010
`define CRF_ETH_PRE_BYTES 16'h0002
`define CRF_HDR_WORDS     16'h0004

`endif

/* hdl/crf_pkg.sv */
package crf_pkg;

    // record type codes carried in the type byte
    typedef enum logic [7:0] {
        LEGACY_RECORD_CODE            = 8'h00,
        HDLC_POS_RECORD_CODE          = 8'h01,
        ethernet_record_code          = 8'h02,
        atm_cell_record_code          = 8'h03,
        aal5_frame_record_code        = 8'h04,
        multichannel_hdlc_record_code = 8'h05,
        multichannel_raw_record_code  = 8'h06,
        multichannel_atm_record_code  = 8'h07
    } crf_rec_code_t;

    typedef enum logic [1:0] {
        CRF_IDLE,
        CRF_CAPT,
        CRF_EMIT
    } crf_state_t;

endpackage

/* hdl/capture_record_formatter.sv */
`timescale 1ns/1ns
`include "crf_params.svh"

module capture_record_formatter
    import crf_pkg::*;
#(
    parameter int DEPTH          = 2048,
    parameter int FRAC_ZERO_BITS = 8
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [4:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWriteData,
    input  wire logic [3:0]  avsByteEnable,
    output logic      [31:0] avsReadData,
    output logic             avsWaitRequest,
    // frame bytes from the mac
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData,
    input  wire logic        rxLast,
    input  wire logic        rxError,
    input  wire logic [1:0]  rxPort,
    // record words towards host memory
    output logic             outValid,
    output logic      [31:0] outData,
    output logic             outLast,
    input  wire logic        outReady,
    // interrupt
    output logic             irq
);

    localparam int AW = $clog2(DEPTH);

    // ======================================================
    // state
    typedef struct packed {
        crf_state_t  st;
        logic        ctrlEn;
        logic [31:0] tsSec;
        logic [31:0] tsFrac;
        logic [31:0] tsInc;
        logic [2:0]  status;
        logic [2:0]  intEn;
        logic        irq;
        logic        waitReq;
        logic [31:0] rdData;
        logic [63:0] recTs;
        logic [15:0] capLen;
        logic [15:0] wireLen;
        logic [1:0]  port;
        logic        trunc;
        logic        rxErr;
        logic        fault;
        logic [15:0] lossTally;
        logic [15:0] lossRec;
        logic        rxMid;
        logic        dropping;
        logic [15:0] wordIdx;
        logic        outValid;
        logic [31:0] outData;
        logic        outLast;
    } crf_regs_t;

    crf_regs_t s_r;
    crf_regs_t s_nxt;

    logic [7:0]    bufMem [DEPTH];
    logic          bufWe;
    logic [AW-1:0] bufAddr;
    logic          rstMeta_r;
    logic          rstSync_r;

    // ======================================================
    // helpers
    function automatic logic [31:0] mergeBe(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] satInc(input logic [15:0] v);
        return (v == `CRF_LOSS_MAX) ? v : v + 16'h0001;
    endfunction

    // lane 0 leaves first, so the high byte goes in lane 0
    function automatic logic [15:0] netOrder(input logic [15:0] v);
        return {v[7:0], v[15:8]};
    endfunction

    function automatic logic [15:0] payWords(input logic [15:0] capLen);
        logic [15:0] n;
        n = capLen + `CRF_ETH_PRE_BYTES + 16'h0003;
        return {2'b00, n[15:2]};
    endfunction

    // ======================================================
    // reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // ======================================================
    // next state
    logic        busReq;
    logic        busDo;
    logic        frameStart;
    logic        takeIt;
    logic        dropNow;
    logic [2:0]  ev;
    logic [15:0] rlen;
    logic [15:0] pw;
    logic [15:0] totWords;
    logic [7:0]  flags;
    logic [31:0] word;
    logic [31:0] fracMask;
    logic        loadOut;
    int          pb;
    int          bi;

    always_comb begin
        s_nxt      = s_r;
        busReq     = avsRead | avsWrite;
        busDo      = busReq & ~s_r.waitReq;
        frameStart = rxValid & ~s_r.rxMid;
        takeIt     = frameStart & s_r.ctrlEn & (s_r.st == CRF_IDLE);
        dropNow    = frameStart ? (s_r.ctrlEn & ~takeIt) : s_r.dropping;
        ev         = 3'b000;
        bufWe      = 1'b0;
        bufAddr    = s_r.capLen[AW-1:0];
        fracMask   = 32'hffffffff << FRAC_ZERO_BITS;
        pw         = payWords(s_r.capLen);
        rlen       = `CRF_HDR_BYTES + {pw[13:0], 2'b00};
        totWords   = `CRF_HDR_WORDS + pw;
        flags      = 8'h00;
        word       = 32'h00000000;
        loadOut    = 1'b0;
        pb         = 0;
        bi         = 0;

        // free running time of day, seconds and fraction
        {s_nxt.tsSec, s_nxt.tsFrac} = {s_r.tsSec, s_r.tsFrac}
                                      + {32'h00000000, s_r.tsInc};

        // bus: waitrequest low one cycle after a request appears
        s_nxt.waitReq = ~(busReq & s_r.waitReq);
        if (busReq & s_r.waitReq) begin
            case (avsAddress)
                `CRF_REG_CTRL:   s_nxt.rdData = {31'h0, s_r.ctrlEn};
                `CRF_REG_STATUS: s_nxt.rdData = {29'h0, s_r.status};
                `CRF_REG_INT_EN: s_nxt.rdData = {29'h0, s_r.intEn};
                `CRF_REG_TS_SEC: s_nxt.rdData = s_r.tsSec;
                `CRF_REG_TS_INC: s_nxt.rdData = s_r.tsInc;
                `CRF_REG_LOSS:   s_nxt.rdData = {16'h0, s_r.lossTally};
                default:         s_nxt.rdData = 32'h00000000;
            endcase
        end
        if (busDo & avsWrite) begin
            case (avsAddress)
                `CRF_REG_CTRL: begin
                    if (avsByteEnable[0]) begin
                        s_nxt.ctrlEn = avsWriteData[`CRF_CTRL_EN_BIT];
                    end
                end
                `CRF_REG_INT_EN: begin
                    if (avsByteEnable[0]) begin
                        s_nxt.intEn = avsWriteData[2:0];
                    end
                end
                `CRF_REG_TS_SEC: begin
                    s_nxt.tsSec  = mergeBe(s_r.tsSec, avsWriteData,
                                           avsByteEnable);
                    s_nxt.tsFrac = 32'h00000000;
                end
                `CRF_REG_TS_INC: begin
                    s_nxt.tsInc = mergeBe(s_r.tsInc, avsWriteData,
                                          avsByteEnable);
                end
                default: begin
                end
            endcase
        end

        // frame tracking
        if (rxValid) begin
            s_nxt.rxMid = ~rxLast;
        end
        if (frameStart) begin
            s_nxt.dropping = dropNow & ~rxLast;
        end else if (rxValid & rxLast) begin
            s_nxt.dropping = 1'b0;
        end

        if (rxValid && rxLast && (s_r.st == CRF_CAPT || takeIt)) begin
            s_nxt.lossTally = 16'h0000;
        end
        // saturating loss count; set beats clear
        if (rxValid && rxLast && dropNow) begin
            s_nxt.lossTally = (s_r.st == CRF_CAPT) ? 16'h0001
                                                  : satInc(s_r.lossTally);
            ev[`CRF_EV_DROP_BIT] = 1'b1;
        end

        case (s_r.st)
            CRF_IDLE: begin
                if (takeIt) begin
                    s_nxt.recTs   = {s_r.tsSec, s_r.tsFrac & fracMask};
                    s_nxt.port    = rxPort;
                    s_nxt.rxErr   = rxError;
                    s_nxt.trunc   = 1'b0;
                    s_nxt.fault   = 1'b0;
                    s_nxt.capLen  = 16'h0001;
                    s_nxt.wireLen = 16'h0001;
                    bufWe         = 1'b1;
                    bufAddr       = '0;
                    s_nxt.st      = CRF_CAPT;
                    // single-byte frame has no later last byte to wait for
                    if (rxLast) begin
                        s_nxt.lossRec = s_r.lossTally;
                        s_nxt.wordIdx = 16'h0000;
                        s_nxt.st      = CRF_EMIT;
                    end
                end
            end
            CRF_CAPT: begin
                if (rxValid) begin
                    s_nxt.rxErr = s_r.rxErr | rxError;
                    // every byte seen on the medium counts
                    if (s_r.wireLen == 16'hffff) begin
                        // length overflow is an internal fault
                        s_nxt.fault = 1'b1;
                    end else begin
                        s_nxt.wireLen = s_r.wireLen + 16'h0001;
                    end
                    if (s_r.capLen < 16'(DEPTH)) begin
                        bufWe        = 1'b1;
                        s_nxt.capLen = s_r.capLen + 16'h0001;
                    end else begin
                        s_nxt.trunc = 1'b1;
                    end
                    if (rxLast) begin
                        s_nxt.lossRec = s_r.lossTally;
                        s_nxt.wordIdx = 16'h0000;
                        s_nxt.st      = CRF_EMIT;
                    end
                end
            end
            CRF_EMIT: begin
                loadOut = ~s_r.outValid | outReady;
                if (s_r.outValid & outReady & s_r.outLast) begin
                    s_nxt.st = CRF_IDLE;
                    ev[`CRF_EV_RECORD_BIT] = 1'b1;
                    ev[`CRF_EV_TRUNC_BIT]  = s_r.trunc;
                end
            end
            default: begin
                s_nxt.st = CRF_IDLE;
            end
        endcase

        flags[1:0]                 = s_r.port;
        flags[`CRF_FLAG_VARLEN_BIT] = 1'b1;
        flags[`CRF_FLAG_TRUNC_BIT]  = s_r.trunc;
        flags[`CRF_FLAG_RXERR_BIT]  = s_r.rxErr;
        flags[`CRF_FLAG_FAULT_BIT]  = s_r.fault;

        case (s_r.wordIdx)
            16'h0000: word = s_r.recTs[31:0];
            16'h0001: word = s_r.recTs[63:32];
            16'h0002: word = {netOrder(rlen), flags, ethernet_record_code};
            16'h0003: word = {netOrder(s_r.wireLen), netOrder(s_r.lossRec)};
            default: begin
                // offset and pad zero, frame follows
                pb = (int'(s_r.wordIdx) - 4) * 4 - 2;
                for (int j = 0; j < 4; j++) begin
                    bi = pb + j;
                    if (bi >= 0 && bi < int'(s_r.capLen)) begin
                        word[j*8 +: 8] = bufMem[bi[AW-1:0]];
                    end
                end
            end
        endcase

        if (loadOut) begin
            s_nxt.outValid = s_r.wordIdx < totWords;
            s_nxt.outData  = word;
            s_nxt.outLast  = s_r.wordIdx == totWords - 16'h0001;
            if (s_r.wordIdx < totWords) begin
                s_nxt.wordIdx = s_r.wordIdx + 16'h0001;
            end
        end else if (s_r.st != CRF_EMIT) begin
            s_nxt.outValid = 1'b0;
            s_nxt.outLast  = 1'b0;
        end

        // sticky events; a set in the clearing cycle survives
        if (busDo & avsWrite & (avsAddress == `CRF_REG_INT_CLR)
            & avsByteEnable[0]) begin
            s_nxt.status = s_r.status & ~avsWriteData[2:0];
        end
        s_nxt.status = s_nxt.status | ev;
        s_nxt.irq    = |(s_nxt.status & s_nxt.intEn);
    end

    // ======================================================
    // registers
    always_ff @(posedge clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            s_r         <= '0;
            s_r.st      <= CRF_IDLE;
            s_r.waitReq <= 1'b1;
            s_r.tsInc   <= `CRF_TS_INC_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // frame store has no reset; only written bytes are read
    always_ff @(posedge clk) begin
        if (bufWe) begin
            bufMem[bufAddr] <= rxData;
        end
    end

    assign avsReadData    = s_r.rdData;
    assign avsWaitRequest = s_r.waitReq;
    assign outValid       = s_r.outValid;
    assign outData        = s_r.outData;
    assign outLast        = s_r.outLast;
    assign irq            = s_r.irq;

    // ======================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync_r);

    a_type_word_code: assert property (
        outValid && s_r.wordIdx == 16'h0003 |-> outData[7:0] == 8'h02)
        else $error("type byte is not ethernet");

    a_flags_fixed_bits: assert property (
        outValid && s_r.wordIdx == 16'h0003 |-> outData[10] && !outData[15]
        && !outData[14]) else $error("flags fixed bits wrong");

    a_loss_saturates: assert property (
        s_r.lossTally == 16'hffff && rxValid && rxLast && dropNow
        && s_r.st == CRF_EMIT |=> s_r.lossTally == 16'hffff)
        else $error("loss tally wrapped");

    a_loss_cleared: assert property (
        s_r.st == CRF_CAPT && rxValid && rxLast && !dropNow
        |=> s_r.lossTally == 16'h0000) else $error("tally not cleared");

    a_frac_low_zero: assert property (
        s_r.st == CRF_CAPT |-> s_r.recTs[FRAC_ZERO_BITS-1:0] == '0)
        else $error("unresolved fraction bits set");

    a_stamp_taken: assert property (
        takeIt |=> s_r.recTs[63:32] == $past(s_r.tsSec))
        else $error("stamp not taken at arrival");

    a_trunc_flag: assert property (
        s_r.st == CRF_CAPT && rxValid && s_r.capLen == 16'(DEPTH)
        |=> s_r.trunc) else $error("truncation not flagged");

    a_rxerr_flag: assert property (
        takeIt && rxError |=> s_r.rxErr) else $error("rx error lost");

    a_wait_one_cycle: assert property (
        (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
        else $error("waitrequest held too long");

    a_hold_word: assert property (
        outValid && !outReady |=> outValid && $stable(outData))
        else $error("word changed under back-pressure");

    c_record_done: cover property (outValid && outReady && outLast);
    c_drop_counted: cover property (rxValid && rxLast && dropNow);
    c_truncated: cover property (s_r.trunc && outLast);
    c_irq_raised: cover property (!irq ##1 irq);

endmodule

/* dv/crf_host_sink.sv */
`timescale 1ns/1ns
// ==========================================================
// host memory sink taking record words
module crf_host_sink (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // record words
    input  wire logic        outValid,
    input  wire logic [31:0] outData,
    input  wire logic        outLast,
    output logic             outReady,
    // 0 always ready, 1 random stalls, 2 fully stalled
    input  wire logic [1:0]  stallMode
);
    logic [31:0] wordQ[$];
    int          recWords[$];
    int          nWords;
    logic [15:0] lfsr;

    // memory may stall at any word, so ready is never assumed
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outReady <= 1'b0;
            lfsr     <= 16'hace1;
            nWords = 0;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            if (outValid && outReady) begin
                wordQ.push_back(outData);
                nWords = nWords + 1;
                if (outLast) begin
                    recWords.push_back(nWords);
                    nWords = 0;
                end
            end
            outReady <= (stallMode == 2'h0) ||
                        (stallMode == 2'h1 && lfsr[0]);
        end
    end
endmodule

/* dv/capture_record_formatter_tb.sv */
`timescale 1ns/1ns
`include "crf_params.svh"
module capture_record_formatter_tb
    import crf_pkg::*;
    ;
    localparam int DEPTH_T = 16;

    logic        clk;
    logic        rst_n;
    logic [4:0]  avsAddress;
    logic        avsRead;
    logic        avsWrite;
    logic [31:0] avsWriteData;
    logic [3:0]  avsByteEnable;
    logic [31:0] avsReadData;
    logic        avsWaitRequest;
    logic        rxValid;
    logic [7:0]  rxData;
    logic        rxLast;
    logic        rxError;
    logic [1:0]  rxPort;
    logic        outValid;
    logic [31:0] outData;
    logic        outLast;
    logic        outReady;
    logic        irq;
    logic [1:0]  stallMode;
    logic [31:0] seed = 32'h00000060;
    logic [31:0] secs;
    logic [31:0] q;
    logic [63:0] lastTs = 64'h0;
    logic [7:0]  fb[$];
    logic [7:0]  keepA[$];
    int          nErrors = 0;
    int          numChecks = 0;
    int          len;
    int          corner[4] = '{1, 16, 17, 40};

    // ==========================================================
    // design and host memory
    capture_record_formatter #(.DEPTH(DEPTH_T), .FRAC_ZERO_BITS(8)) DUT (
        .clk(clk), .rst_n(rst_n), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast),
        .rxError(rxError), .rxPort(rxPort), .outValid(outValid),
        .outData(outData), .outLast(outLast), .outReady(outReady),
        .irq(irq));
    crf_host_sink host (
        .clk(clk), .rst_n(rst_n), .outValid(outValid),
        .outData(outData), .outLast(outLast), .outReady(outReady),
        .stallMode(stallMode));

    always #20 clk = ~clk;

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // header, offset and pad, then the frame padded to whole words
    function automatic logic [15:0] expRlen(input int cap);
        return 16'(16 + 4 * ((cap + 5) / 4));
    endfunction

    task automatic stopTest();
        $display("checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: word %h not %h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        numChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: bit %b not %b", $time, got, exp);
        end
    endtask

    // one avalon access; waits for waitrequest low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avsAddress   <= a;
        avsWriteData <= d;
        avsWrite     <= wr;
        avsRead      <= !wr;
        @(posedge clk);
        while (avsWaitRequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        q = avsReadData;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
        if (n == 20) begin
            nErrors++;
            stopTest();
        end
    endtask

    task automatic sendFrame(input int n, input logic [1:0] port,
                             input logic err);
        fb.delete();
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            fb.push_back(8'(xs()));
            rxValid <= 1'b1;
            rxData  <= fb[i];
            rxLast  <= (i == n - 1);
            rxError <= err && (i == n - 1);
            rxPort  <= port;
        end
        @(posedge clk);
        rxValid <= 1'b0;
        rxLast  <= 1'b0;
        rxError <= 1'b0;
    endtask

    // pops one record from host memory and checks it field by field
    task automatic checkRec(input int wl, input logic [1:0] port,
                            input logic err, input logic [15:0] lc);
        logic [31:0] w[4];
        logic [7:0]  by[$];
        logic [15:0] rl;
        logic [15:0] wl16;
        logic [7:0]  fl;
        logic [31:0] ex;
        int          cap;
        int          n;
        n = 0;
        while (host.recWords.size() == 0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n == 400) begin
            nErrors++;
            stopTest();
        end
        cap = (wl > DEPTH_T) ? DEPTH_T : wl;
        rl = expRlen(cap);
        wl16 = 16'(wl);
        fl = {3'h0, err, wl > DEPTH_T, 1'b1, port};
        for (int i = 0; i < 4; i++) w[i] = host.wordQ.pop_front();
        chk(w[1], secs);
        chk({24'h0, w[0][7:0]}, 32'h0);
        chkBit({w[1], w[0]} > lastTs, 1'b1);
        lastTs = {w[1], w[0]};
        ex = {rl[7:0], rl[15:8], fl, ethernet_record_code};
        chk(w[2], ex);
        ex = {wl16[7:0], wl16[15:8], lc[7:0], lc[15:8]};
        chk(w[3], ex);
        chk(32'(host.recWords.pop_front() * 4), 32'(rl));
        by = {8'h00, 8'h00};
        for (int i = 0; i < cap; i++) by.push_back(fb[i]);
        while (by.size() % 4 != 0) by.push_back(8'h00);
        for (int k = 0; k < by.size(); k += 4) begin
            ex = {by[k+3], by[k+2], by[k+1], by[k]};
            chk(host.wordQ.pop_front(), ex);
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {avsAddress, avsRead, avsWrite, avsWriteData} = '0;
        avsByteEnable = 4'hf;
        {rxValid, rxData, rxLast, rxError, rxPort} = '0;
        stallMode = 2'h1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values, the last address is unmapped
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0);
            chk(q, (i == 5) ? `CRF_TS_INC_RESET : 32'h0);
        end
        secs = xs();
        bus(1'b1, `CRF_REG_TS_SEC, secs);
        bus(1'b1, `CRF_REG_INT_EN, 32'h1);
        bus(1'b1, `CRF_REG_CTRL, 32'h1);
        // interrupt raised, cleared, then masked
        sendFrame(3, 2'h1, 1'b0);
        checkRec(3, 2'h1, 1'b0, 16'h0);
        bus(1'b0, `CRF_REG_STATUS, 32'h0);
        chk(q, 32'h1);
        chkBit(irq, 1'b1);
        bus(1'b1, `CRF_REG_INT_CLR, 32'h1);
        bus(1'b0, `CRF_REG_STATUS, 32'h0);
        chk(q, 32'h0);
        chkBit(irq, 1'b0);
        bus(1'b1, `CRF_REG_INT_EN, 32'h0);
        sendFrame(5, 2'h2, 1'b0);
        checkRec(5, 2'h2, 1'b0, 16'h0);
        bus(1'b0, `CRF_REG_STATUS, 32'h0);
        chkBit(irq, 1'b0);
        bus(1'b1, `CRF_REG_INT_EN, 32'h1);
        bus(1'b0, `CRF_REG_STATUS, 32'h0);
        chkBit(irq, 1'b1);
        // corner lengths first, then random frames under back-pressure
        for (int i = 0; i < 16; i++) begin
            len = (i < 4) ? corner[i] : int'(xs() % 16) + 1;
            q = xs();
            sendFrame(len, q[1:0], q[2]);
            checkRec(len, q[1:0], q[2], 16'h0);
        end
        // losses while the host stalls, then saturation
        stallMode <= 2'h2;
        sendFrame(4, 2'h3, 1'b0);
        keepA = fb;
        sendFrame(2, 2'h0, 1'b0);
        sendFrame(5, 2'h0, 1'b0);
        bus(1'b0, `CRF_REG_LOSS, 32'h0);
        chk(q, 32'h2);
        repeat (65540) begin
            @(posedge clk);
            rxValid <= 1'b1;
            rxLast  <= 1'b1;
        end
        @(posedge clk);
        rxValid <= 1'b0;
        rxLast  <= 1'b0;
        bus(1'b0, `CRF_REG_LOSS, 32'h0);
        chk(q, 32'h0000ffff);
        fb = keepA;
        stallMode <= 2'h0;
        checkRec(4, 2'h3, 1'b0, 16'h0);
        sendFrame(6, 2'h2, 1'b1);
        checkRec(6, 2'h2, 1'b1, 16'hffff);
        sendFrame(2, 2'h1, 1'b0);
        checkRec(2, 2'h1, 1'b0, 16'h0);
        stopTest();
    end
endmodule
